// ===== rtl/uic_pkg.sv
// shared constants and carriers for the two-wire / clock-synchronous receive block
package uic_pkg;
    localparam logic [2:0] MODE_DISABLED = 3'h0;
    localparam logic [2:0] MODE_SYNC     = 3'h1;
    localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
    localparam int         WORD_W        = 9;
    localparam logic [3:0] CNT_ZERO      = 4'h0;
    localparam logic [3:0] CNT_ONE       = 4'h1;
    localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
    localparam logic [3:0] DATA_BITS     = 4'h8;
    localparam logic [3:0] ACK_BIT       = 4'h9;

    typedef struct packed {
        logic [2:0] serialModeField;
        logic       twoWireEnable;
        logic       interruptSourceSelect;
        logic       clockDelaySelect;
        logic       clockPolaritySelect;
        logic       conditionOutputSelect;
        logic       txEventSelect;
    } uic_cfg_t;

    typedef struct packed {
        logic rxRequest;
        logic txRequest;
        logic conditionEvent;
    } uic_evt_t;

    typedef logic [WORD_W-1:0] uic_word_t;
endpackage

// ===== rtl/uic_receiver.sv
// receive path, bus condition detection and line control of the serial channel
//
// Notes on behaviour
// - sync mode clocks from the serial clock pin; two-wire mode clocks from the rx pin
// - two-wire mode reports true pin levels; sync mode only the rx line level, and only when direction is input
// - data line starts at the port value latched while the mode field is disabled
// - clock line idles high without clock delay, low with clock delay and automatic condition output
// - rx request: ack detect with ack setting, else eighth-bit falling edge
// - tx request: ninth-bit rising edge, or following falling edge with clock delay
// - sync mode stores first received bit in b0, eighth in b7
// - two-wire ack setting stores first bit in b7, eighth in b0
// - rx setting: eighth-bit falling transfer puts bits one to seven in b6..b0, eighth in b8
// - rx setting with clock delay: ninth-bit rising transfer pushes a second word with bits in b7..b0, b8 clear
// - data falling while clock high is a start condition
// - data rising while clock high is a stop condition
// - one shared condition event; bus busy flag tells start from stop
// - with automatic condition output the event marks generation done, not detection
`timescale 1ns/10ps
module uic_receiver #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire uic_pkg::uic_cfg_t cfg,
    input  wire logic             portOutputData,
    input  wire logic             rxPinIsInput,
    input  wire logic             conditionDone,
    input  wire logic             serialClockPin,
    input  wire logic             serialRxPinIn,
    input  wire logic             serialTxPinIn,
    output logic                  serialTxPinOut,
    output logic                  serialTxPinOe,
    output logic                  serialRxPinOut,
    output logic                  serialRxPinOe,
    output logic                  rxLineLevel,
    output logic                  dataLineLevel,
    output uic_pkg::uic_evt_t     events,
    output logic                  busBusyFlag,
    output logic                  rxValid,
    output uic_pkg::uic_word_t    rxData,
    input  wire logic             rxReady,
    output logic                  rxBufFull
);
    if (BUF_DEPTH != 2) begin : g_chk
        $error("uic_receiver supports only a two-entry buffer");
    end

    // ------------------------------------------------------------
    // input synchronisers and filtered levels
    // ------------------------------------------------------------
    logic [2:0] clkSync, sclSync, sdaSync;
    logic       clkF, sclF, sdaF;
    logic       next_clkF, next_sclF, next_sdaF;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync <= 3'h7;
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
            clkF    <= 1'b1;
            sclF    <= 1'b1;
            sdaF    <= 1'b1;
        end else begin
            clkSync <= {clkSync[1:0], serialClockPin};
            sclSync <= {sclSync[1:0], serialRxPinIn};
            sdaSync <= {sdaSync[1:0], serialTxPinIn};
            clkF    <= next_clkF;
            sclF    <= next_sclF;
            sdaF    <= next_sdaF;
        end
    end
    always_comb begin
        next_clkF = (clkSync[1] == clkSync[2]) ? clkSync[2] : clkF;
        next_sclF = (sclSync[1] == sclSync[2]) ? sclSync[2] : sclF;
        next_sdaF = (sdaSync[1] == sdaSync[2]) ? sdaSync[2] : sdaF;
    end
    logic clkRise, clkFall, sclRise, sclFall, sdaRise, sdaFall;
    assign clkRise = next_clkF & ~clkF;
    assign clkFall = ~next_clkF & clkF;
    assign sclRise = next_sclF & ~sclF;
    assign sclFall = ~next_sclF & sclF;
    assign sdaRise = next_sdaF & ~sdaF;
    assign sdaFall = ~next_sdaF & sdaF;
    logic i2cMode, syncMode, startDet, stopDet;
    assign i2cMode  = cfg.serialModeField == uic_pkg::MODE_TWO_WIRE && cfg.twoWireEnable;
    assign syncMode = cfg.serialModeField == uic_pkg::MODE_SYNC && !cfg.twoWireEnable;
    assign startDet = sdaFall && sclF && !sclFall;
    assign stopDet  = sdaRise && sclF && !sclFall;

    // ------------------------------------------------------------
    // bit sequencing, events and line control
    // ------------------------------------------------------------
    logic [3:0]         bitCnt, next_bitCnt;
    logic [7:0]         shReg, next_shReg;
    logic               active, next_active, sdaInit, next_sdaInit;
    logic               next_busy, next_txOut, next_txOe, next_sclOe;
    logic               next_rxLevel, next_dataLevel, pushReq, sample;
    uic_pkg::uic_evt_t  next_evt;
    uic_pkg::uic_word_t pushWord;
    always_comb begin
        next_bitCnt  = bitCnt;
        next_shReg   = shReg;
        next_active  = active;
        next_busy    = busBusyFlag;
        next_sdaInit = sdaInit;
        next_evt     = '0;
        pushReq      = 1'b0;
        pushWord     = '0;
        sample       = 1'b0;
        if (cfg.serialModeField == uic_pkg::MODE_DISABLED) begin
            next_sdaInit = portOutputData;
        end
        if (startDet) begin
            next_busy = 1'b1;
        end else if (stopDet) begin
            next_busy = 1'b0;
        end
        next_evt.conditionEvent = cfg.conditionOutputSelect ? conditionDone
                                                            : (startDet | stopDet);
        if (i2cMode) begin
            if (startDet) begin
                next_active = 1'b1;
                next_bitCnt = uic_pkg::CNT_ZERO;
            end else if (stopDet) begin
                next_active = 1'b0;
                next_bitCnt = uic_pkg::CNT_ZERO;
            end else if (active && sclRise) begin
                if (bitCnt < uic_pkg::DATA_BITS) begin
                    next_shReg = {shReg[6:0], sdaF};
                end
                if (bitCnt != uic_pkg::ACK_BIT) begin
                    next_bitCnt = bitCnt + uic_pkg::CNT_ONE;
                end
                if (bitCnt == uic_pkg::DATA_BITS) begin
                    if (!cfg.interruptSourceSelect) begin
                        pushReq            = 1'b1;
                        pushWord           = {1'b0, shReg};
                        next_evt.rxRequest = ~sdaF;
                    end else if (cfg.clockDelaySelect) begin
                        pushReq  = 1'b1;
                        pushWord = {1'b0, shReg};
                    end
                    next_evt.txRequest = ~cfg.clockDelaySelect;
                end
            end else if (active && sclFall) begin
                if (bitCnt == uic_pkg::DATA_BITS && cfg.interruptSourceSelect) begin
                    pushReq            = 1'b1;
                    pushWord           = {shReg[0], 1'b0, shReg[7:1]};
                    next_evt.rxRequest = 1'b1;
                end
                if (bitCnt == uic_pkg::ACK_BIT) begin
                    next_evt.txRequest = cfg.clockDelaySelect;
                    next_bitCnt        = uic_pkg::CNT_ZERO;
                end
            end
        end else if (syncMode) begin
            sample = cfg.clockPolaritySelect ? clkFall : clkRise;
            if (sample) begin
                next_shReg  = {sclF, shReg[7:1]};
                next_bitCnt = bitCnt + uic_pkg::CNT_ONE;
                if (bitCnt == uic_pkg::CNT_ZERO && !cfg.txEventSelect) begin
                    next_evt.txRequest = 1'b1;
                end
                if (bitCnt == uic_pkg::SYNC_LAST_BIT) begin
                    pushReq            = 1'b1;
                    pushWord           = {1'b0, sclF, shReg[7:1]};
                    next_evt.rxRequest = 1'b1;
                    next_evt.txRequest = cfg.txEventSelect;
                    next_bitCnt        = uic_pkg::CNT_ZERO;
                end
            end
        end else begin
            next_active = 1'b0;
            next_bitCnt = uic_pkg::CNT_ZERO;
        end
        next_rxLevel   = (i2cMode || rxPinIsInput) ? sclF : 1'b0;
        next_dataLevel = i2cMode ? sdaF : 1'b0;
        next_txOut     = syncMode ? ~cfg.clockPolaritySelect : 1'b0;
        next_txOe      = syncMode || (i2cMode && !sdaInit);
        // the far master owns the clock except between transfers when clock delay is set and this side generates the conditions
        next_sclOe     = i2cMode && cfg.clockDelaySelect && cfg.conditionOutputSelect
                         && next_bitCnt == uic_pkg::CNT_ZERO;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt         <= '0;
            shReg          <= '0;
            active         <= 1'b0;
            sdaInit        <= 1'b1;
            busBusyFlag    <= 1'b0;
            events         <= '0;
            rxLineLevel    <= 1'b0;
            dataLineLevel  <= 1'b0;
            serialTxPinOut <= 1'b0;
            serialTxPinOe  <= 1'b0;
            serialRxPinOut <= 1'b0;
            serialRxPinOe  <= 1'b0;
        end else begin
            bitCnt         <= next_bitCnt;
            shReg          <= next_shReg;
            active         <= next_active;
            sdaInit        <= next_sdaInit;
            busBusyFlag    <= next_busy;
            events         <= next_evt;
            rxLineLevel    <= next_rxLevel;
            dataLineLevel  <= next_dataLevel;
            serialTxPinOut <= next_txOut;
            serialTxPinOe  <= next_txOe;
            serialRxPinOut <= 1'b0;
            serialRxPinOe  <= next_sclOe;
        end
    end

    // ------------------------------------------------------------
    // two-entry receive buffer, head register drives the outputs
    // ------------------------------------------------------------
    uic_pkg::uic_word_t tailData, next_headData, next_tailData;
    logic               tailValid, next_headValid, next_tailValid;
    always_comb begin
        next_headValid = rxValid;
        next_headData  = rxData;
        next_tailValid = tailValid;
        next_tailData  = tailData;
        if (rxValid && rxReady) begin
            next_headValid = tailValid;
            next_headData  = tailData;
            next_tailValid = 1'b0;
        end
        if (pushReq && !tailValid) begin
            if (!next_headValid) begin
                next_headValid = 1'b1;
                next_headData  = pushWord;
            end else begin
                next_tailValid = 1'b1;
                next_tailData  = pushWord;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxValid   <= 1'b0;
            rxData    <= '0;
            tailValid <= 1'b0;
            tailData  <= '0;
            rxBufFull <= 1'b0;
        end else begin
            rxValid   <= next_headValid;
            rxData    <= next_headData;
            tailValid <= next_tailValid;
            tailData  <= next_tailData;
            rxBufFull <= next_tailValid;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_start_sets_busy: assert property (startDet |=> busBusyFlag)
        else $error("start condition did not set bus busy");
    a_stop_clears_busy: assert property (stopDet && !startDet |=> !busBusyFlag)
        else $error("stop condition did not clear bus busy");
    a_ack_msb_store: assert property (i2cMode && active && sclRise && !startDet && !stopDet
        && bitCnt == uic_pkg::DATA_BITS && !cfg.interruptSourceSelect
        |-> pushReq && pushWord[7:0] == shReg)
        else $error("ack setting did not store msb first");
    a_split_store: assert property (i2cMode && active && sclFall && !startDet && !stopDet
        && bitCnt == uic_pkg::DATA_BITS && cfg.interruptSourceSelect
        |-> pushWord[8] == shReg[0] && pushWord[6:0] == shReg[7:1])
        else $error("rx setting split store wrong");
    a_ack_request: assert property (i2cMode && active && sclRise && !startDet && !stopDet
        && bitCnt == uic_pkg::DATA_BITS && !cfg.interruptSourceSelect && !sdaF
        |=> events.rxRequest)
        else $error("ack detection raised no rx request");
    a_tx_delay_req: assert property (i2cMode && active && sclFall && !startDet && !stopDet
        && bitCnt == uic_pkg::ACK_BIT && cfg.clockDelaySelect |=> events.txRequest)
        else $error("delayed tx request missing");
    a_lsb_store: assert property (syncMode && sample && bitCnt == uic_pkg::SYNC_LAST_BIT
        |-> pushReq && pushWord[7:0] == {sclF, shReg[7:1]})
        else $error("sync mode did not store lsb first");
    a_level_report: assert property (i2cMode |=> rxLineLevel == $past(sclF))
        else $error("two-wire clock level not reported");
    a_scl_idle_low: assert property (i2cMode && cfg.clockDelaySelect && cfg.conditionOutputSelect
        && next_bitCnt == uic_pkg::CNT_ZERO |=> serialRxPinOe)
        else $error("clock line not held low between transfers");
    a_filter_hold: assert property (sclSync[1] != sclSync[2] |=> sclF == $past(sclF))
        else $error("filtered clock changed on disagreeing samples");
    a_cond_source: assert property (cfg.conditionOutputSelect && !conditionDone
        |=> !events.conditionEvent)
        else $error("condition event fired without generation done");

    c_start_seen: cover property (i2cMode && startDet);
    c_ack_request: cover property (events.rxRequest && i2cMode);
    c_sync_byte: cover property (syncMode && pushReq);
    c_buffer_full: cover property (rxBufFull && !rxReady);
endmodule

// ===== testbench/uic_bus_model.sv
// bus-side partner: drives the shared clock and data lines and the sync transfer clock
`timescale 1ns/10ps
module uic_bus_model (
    output logic sclDrive,
    output logic sdaDrive,
    output logic syncClk
);
    // released lines read high through the pull-ups; the sync clock stands still between frames
    initial begin
        sclDrive = 1'b1;
        sdaDrive = 1'b1;
        syncClk  = 1'b1;
    end

    // -----------------------------------------------------------------
    // bus conditions and bits, 160 ns link clock
    // -----------------------------------------------------------------
    task automatic busStart();
        sdaDrive = 1'b0;
        #40 sclDrive = 1'b0;
    endtask

    task automatic busStop();
        #40 sdaDrive = 1'b0;
        #40 sclDrive = 1'b1;
        #40 sdaDrive = 1'b1;
        #80;
    endtask

    // data only moves while the clock is low, well clear of its edges
    task automatic busBit(input logic b);
        #40 sdaDrive = b;
        #40 sclDrive = 1'b1;
        #80 sclDrive = 1'b0;
    endtask

    task automatic busByte(input logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) busBit(d[i]);
        busBit(ack);
    endtask

    // sync mode: the rx pin carries data, first bit first; pol picks the sampling edge
    task automatic syncByte(input logic [7:0] d, input logic pol);
        for (int i = 0; i < 8; i++) begin
            syncClk = pol;
            #40 sclDrive = d[i];
            #40 syncClk = ~pol;
            #80;
        end
        sclDrive = 1'b1;
    endtask
endmodule

// ===== testbench/uic_receiver_test.sv
// self-checking bench for the receive path, bus conditions and line control
`timescale 1ns/10ps
module uic_receiver_test;
    logic               core_clk, rst_n, portOutputData, rxPinIsInput, conditionDone, rxReady;
    logic               sclDrive, sdaDrive, syncClk, serialRxPinIn, serialTxPinIn;
    logic               serialTxPinOut, serialTxPinOe, serialRxPinOut, serialRxPinOe;
    logic               rxLineLevel, dataLineLevel, busBusyFlag, rxValid, rxBufFull;
    uic_pkg::uic_cfg_t  cfg;
    uic_pkg::uic_evt_t  events;
    uic_pkg::uic_word_t rxData;
    int                 err_total, check_count, rxCount, txCount, condCount;

    // open-drain wires: low when any party drives low
    assign serialRxPinIn = sclDrive & (serialRxPinOe ? serialRxPinOut : 1'b1);
    assign serialTxPinIn = sdaDrive & (serialTxPinOe ? serialTxPinOut : 1'b1);

    uic_bus_model u_uic_bus_model (.sclDrive(sclDrive), .sdaDrive(sdaDrive), .syncClk(syncClk));

    uic_receiver #(.BUF_DEPTH(2)) u_uic_receiver (
        .core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .portOutputData(portOutputData),
        .rxPinIsInput(rxPinIsInput), .conditionDone(conditionDone),
        .serialClockPin(syncClk), .serialRxPinIn(serialRxPinIn), .serialTxPinIn(serialTxPinIn),
        .serialTxPinOut(serialTxPinOut), .serialTxPinOe(serialTxPinOe),
        .serialRxPinOut(serialRxPinOut), .serialRxPinOe(serialRxPinOe),
        .rxLineLevel(rxLineLevel), .dataLineLevel(dataLineLevel), .events(events),
        .busBusyFlag(busBusyFlag), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .rxBufFull(rxBufFull));

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        rxCount   <= rxCount + int'(events.rxRequest);
        txCount   <= txCount + int'(events.txRequest);
        condCount <= condCount + int'(events.conditionEvent);
    end

    // -----------------------------------------------------------------
    // shared helpers
    // -----------------------------------------------------------------
    task automatic check_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input uic_pkg::uic_word_t exp,
                              input uic_pkg::uic_word_t got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic setCfg(input logic [2:0] mode, input logic tw, iss, cd, cos);
        @(negedge core_clk);
        cfg = '{mode, tw, iss, cd, 1'b0, cos, 1'b0};
        repeat (6) @(negedge core_clk);
        rxCount = 0;
        txCount = 0;
        condCount = 0;
    endtask

    // waits up to 100 cycles for rxValid; compares the head word, then pops it
    task automatic drain(input uic_pkg::uic_word_t exp);
        int n;
        n = 0;
        @(negedge core_clk);
        while (rxValid !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check_word("rxData", exp, rxData);
        rxReady = 1'b1;
        @(negedge core_clk);
        rxReady = 1'b0;
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic test_lines();
        setCfg(uic_pkg::MODE_DISABLED, 1'b1, 1'b0, 1'b0, 1'b0);
        portOutputData = 1'b0;
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b0, 1'b0, 1'b0);
        check_bit("dataDriveEnable", 1'b1, serialTxPinOe);
        check_bit("dataDrive", 1'b0, serialTxPinOut);
        setCfg(uic_pkg::MODE_DISABLED, 1'b1, 1'b0, 1'b0, 1'b0);
        portOutputData = 1'b1;
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b0, 1'b1, 1'b1);
        check_bit("dataDriveEnable", 1'b0, serialTxPinOe);
        check_bit("clockDriveEnable", 1'b1, serialRxPinOe);
        check_bit("clockDrive", 1'b0, serialRxPinOut);
        rxPinIsInput = 1'b0;
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b0, 1'b0, 1'b0);
        check_bit("clockDriveEnable", 1'b0, serialRxPinOe);
        check_bit("clockLevel", 1'b1, rxLineLevel);
        check_bit("dataLevel", 1'b1, dataLineLevel);
        setCfg(uic_pkg::MODE_SYNC, 1'b0, 1'b0, 1'b0, 1'b0);
        check_bit("clockLevel", 1'b0, rxLineLevel);
        rxPinIsInput = 1'b1;
        repeat (2) @(negedge core_clk);
        check_bit("clockLevel", 1'b1, rxLineLevel);
        $display("test_lines done");
    endtask

    task automatic test_ack();
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b0, 1'b0, 1'b0);
        u_uic_bus_model.busStart();
        #40;
        check_word("startEvents", 9'h001, 9'(condCount));
        check_bit("busBusy", 1'b1, busBusyFlag);
        u_uic_bus_model.busByte(8'ha5, 1'b0);
        u_uic_bus_model.busByte(8'h3c, 1'b1);
        u_uic_bus_model.busByte(8'h0f, 1'b0);
        #40;
        check_bit("bufFull", 1'b1, rxBufFull);
        check_word("rxRequests", 9'h002, 9'(rxCount));
        check_word("txRequests", 9'h003, 9'(txCount));
        u_uic_bus_model.busStop();
        check_word("stopEvents", 9'h002, 9'(condCount));
        check_bit("busBusy", 1'b0, busBusyFlag);
        drain(9'h0a5);
        drain(9'h03c);
        check_bit("rxValid", 1'b0, rxValid);
        $display("test_ack done");
    endtask

    task automatic test_split();
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b1, 1'b0, 1'b0);
        u_uic_bus_model.busStart();
        u_uic_bus_model.busByte(8'h96, 1'b1);
        u_uic_bus_model.busByte(8'h5b, 1'b0);
        u_uic_bus_model.busStop();
        check_word("rxRequests", 9'h002, 9'(rxCount));
        check_word("txRequests", 9'h002, 9'(txCount));
        drain(9'h04b);
        drain(9'h12d);
        $display("test_split done");
    endtask

    task automatic test_delay();
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b1, 1'b1, 1'b0);
        check_bit("clockDriveEnable", 1'b0, serialRxPinOe);
        u_uic_bus_model.busStart();
        u_uic_bus_model.busByte(8'hc3, 1'b1);
        u_uic_bus_model.busStop();
        check_word("rxRequests", 9'h001, 9'(rxCount));
        check_word("txRequests", 9'h001, 9'(txCount));
        drain(9'h161);
        drain(9'h0c3);
        $display("test_delay done");
    endtask

    task automatic test_sync();
        setCfg(uic_pkg::MODE_SYNC, 1'b0, 1'b0, 1'b0, 1'b0);
        u_uic_bus_model.syncByte(8'hc1, 1'b0);
        #40;
        check_word("rxRequests", 9'h001, 9'(rxCount));
        check_word("txRequests", 9'h001, 9'(txCount));
        drain(9'h0c1);
        // falling-edge sampling, tx request at the last bit
        @(negedge core_clk);
        cfg = '{uic_pkg::MODE_SYNC, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        u_uic_bus_model.syncByte(8'h3a, 1'b1);
        #40;
        check_word("rxRequests", 9'h002, 9'(rxCount));
        check_word("txRequests", 9'h002, 9'(txCount));
        drain(9'h03a);
        $display("test_sync done");
    endtask

    task automatic test_cond();
        setCfg(uic_pkg::MODE_TWO_WIRE, 1'b1, 1'b0, 1'b0, 1'b1);
        conditionDone = 1'b1;
        @(negedge core_clk);
        conditionDone = 1'b0;
        repeat (3) @(negedge core_clk);
        check_word("doneEvents", 9'h001, 9'(condCount));
        u_uic_bus_model.busStart();
        #40;
        check_word("doneEvents", 9'h001, 9'(condCount));
        check_bit("busBusy", 1'b1, busBusyFlag);
        u_uic_bus_model.busStop();
        check_bit("busBusy", 1'b0, busBusyFlag);
        $display("test_cond done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        cfg = '0;
        portOutputData = 1'b1;
        rxPinIsInput = 1'b1;
        conditionDone = 1'b0;
        rxReady = 1'b0;
        {err_total, check_count, rxCount, txCount, condCount} = '0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        test_lines();
        test_ack();
        test_split();
        test_delay();
        test_sync();
        test_cond();
        complete_run();
    end

    // all scenarios take well under 20 us
    initial begin
        #100000;
        err_total++;
        $display("mismatch watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
